// ===== reload_timer_regs.svh
// Notes on behaviour
// - two-bit mode field selects operating mode
// - timer mode counts down selected internal source
// - underflow reloads; period is set value plus one
// - counter runs only while start flag set
// - timer underflow raises interrupt request
// - data register read returns current count
// - write while stopped loads reload and counter
// - write while running loads reload only
// - gate function lets count pin suspend counting
// - timer pulse output toggles on each underflow
// - event mode counts chosen edge on pin
// - event source may be another timer's overflow
// - direction from software bit or pulse pin
// - event mode reloads on overflow or underflow
// - up divides by FFFF-n+1, down n+1
// - event wrap raises interrupt request
// - free-run wraps without reloading
// - event pulse output toggles on each wrap
// - pulse pin: port, pulse out or direction
`ifndef RELOAD_TIMER_REGS_SVH
`define RELOAD_TIMER_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_CTRL    8'h00
`define OFS_MODE    8'h04
`define OFS_DATA    8'h08
`define OFS_RELOAD  8'h0C
`define OFS_STATUS  8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_START      0
`define MODE_OP_LSB     0
`define MODE_PULSE      2
`define MODE_GATE_LSB   3
`define MODE_DIR_PIN    5
`define MODE_FALL       6
`define MODE_FREE       7
`define MODE_CLK_LSB    8
`define MODE_EVT_LSB    10
`define MODE_UP         12
`define MODE_W          13

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define MODE_RST        13'h0000
`define CNT_RST         16'h0000
`define CNT_TOP         16'hFFFF
`define CNT_BOTTOM      16'h0000
`define DIV8_LAST       3'h7
`define DIV32_LAST      5'h1F
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== reload_timer_pkg.sv
package reload_timer_pkg;

	typedef enum logic [1:0] {
		OP_TIMER,
		OP_EVENT,
		OP_ONESHOT,
		OP_PWM
	} op_e;

	typedef enum logic [1:0] {
		SRC_UNDIV,
		SRC_DIV8,
		SRC_DIV32,
		SRC_SUB32
	} src_e;

	typedef enum logic [1:0] {
		EVT_PIN,
		EVT_SECOND_B,
		EVT_FIRST_X,
		EVT_THIRD_X
	} evt_e;

	typedef struct packed {
		logic       up;
		evt_e       evt;
		src_e       src;
		logic       free_run;
		logic       fall;
		logic       dir_pin;
		logic [1:0] gate;
		logic       pulse;
		op_e        op;
	} cfg_s;

endpackage

// ===== count_source.sv
`timescale 1ns/1ns
`include "reload_timer_regs.svh"

module count_source (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                sub_tick,
	input  wire reload_timer_pkg::src_e sel,
	output logic                     tick
);
	import reload_timer_pkg::*;

	logic [4:0] presc_r;
	logic [4:0] sub_r;

	// ---------------------------------------------------------------
	// free running prescalers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			presc_r <= 5'h00;
		end else begin
			presc_r <= presc_r + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sub_r <= 5'h00;
		end else if (sub_tick) begin
			sub_r <= sub_r + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// source select
	// ---------------------------------------------------------------
	always_comb begin
		case (sel)
			SRC_UNDIV: tick = 1'b1;
			SRC_DIV8:  tick = (presc_r[2:0] == `DIV8_LAST);
			SRC_DIV32: tick = (presc_r == `DIV32_LAST);
			SRC_SUB32: tick = sub_tick && (sub_r == `DIV32_LAST);
			default:   tick = 1'b0;
		endcase
	end

endmodule // count_source

// ===== reload_timer.sv
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "reload_timer_regs.svh"

module reload_timer #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 16
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_B,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic [2:0]        S_AXI_AWPROT,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic [2:0]        S_AXI_ARPROT,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              COUNT_INPUT_PIN,
	input  wire logic              PULSE_OUTPUT_PIN_I,
	output logic                   PULSE_OUTPUT_PIN_O,
	output logic                   PULSE_OUTPUT_PIN_OE,
	input  wire logic              PORT_DATA,
	input  wire logic              PORT_DIR,
	input  wire logic              SUBCLOCK_TICK,
	input  wire logic              SECOND_B_GROUP_TIMER_OVF,
	input  wire logic              FIRST_X_TIMER_OVF,
	input  wire logic              THIRD_X_TIMER_OVF,
	output logic                   IRQ_REQ
);
	import reload_timer_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic              aw_held_r;
	logic              w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              wr_go;
	logic              wr_ctrl;
	logic              wr_mode;
	logic              wr_data;
	logic              wr_hit;
	logic              ar_hs;
	logic              start_r;
	logic [`MODE_W-1:0] mode_r;
	logic [CNT_W-1:0]  reload_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic [CNT_W-1:0]  wd16;
	logic [`MODE_W-1:0] wmode;
	cfg_s              cfg;
	logic              is_timer;
	logic              is_event;
	logic              src_tick;
	logic              gate_ok;
	logic              cin_prev_r;
	logic              pin_edge;
	logic              evt_tick;
	logic              up;
	logic              tick;
	logic              wrap_pt;
	logic              wrap;
	logic              reload_evt;
	logic              pout_r;
	logic              irq_r;

	// ---------------------------------------------------------------
	// write channel
	// ---------------------------------------------------------------
	assign S_AXI_AWREADY = !aw_held_r;
	assign S_AXI_WREADY  = !w_held_r;
	assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
	assign wr_ctrl = wr_go && (awaddr_r == `OFS_CTRL);
	assign wr_mode = wr_go && (awaddr_r == `OFS_MODE);
	assign wr_data = wr_go && (awaddr_r == `OFS_DATA);
	assign wr_hit  = wr_ctrl || wr_mode || wr_data;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (S_AXI_AWVALID && !aw_held_r) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= S_AXI_AWADDR;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (S_AXI_WVALID && !w_held_r) begin
			w_held_r <= 1'b1;
			wdata_r  <= S_AXI_WDATA;
			wstrb_r  <= S_AXI_WSTRB;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP  = bresp_r;

	// byte lanes merged over the present value
	always_comb begin
		wd16  = reload_r;
		wmode = mode_r;
		if (wstrb_r[0]) begin
			wd16[7:0]  = wdata_r[7:0];
			wmode[7:0] = wdata_r[7:0];
		end
		if (wstrb_r[1]) begin
			wd16[15:8]           = wdata_r[15:8];
			wmode[`MODE_W-1:8]   = wdata_r[`MODE_W-1:8];
		end
	end

	// ---------------------------------------------------------------
	// control and mode registers
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			start_r <= 1'b0;
		end else if (wr_ctrl && wstrb_r[0]) begin
			start_r <= wdata_r[`CTRL_START];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			mode_r <= `MODE_RST;
		end else if (wr_mode) begin
			mode_r <= wmode;
		end
	end

	always_comb begin
		cfg          = '0;
		cfg.op       = op_e'(mode_r[`MODE_OP_LSB +: 2]);
		cfg.pulse    = mode_r[`MODE_PULSE];
		cfg.gate     = mode_r[`MODE_GATE_LSB +: 2];
		cfg.dir_pin  = mode_r[`MODE_DIR_PIN];
		cfg.fall     = mode_r[`MODE_FALL];
		cfg.free_run = mode_r[`MODE_FREE];
		cfg.src      = src_e'(mode_r[`MODE_CLK_LSB +: 2]);
		cfg.evt      = evt_e'(mode_r[`MODE_EVT_LSB +: 2]);
		cfg.up       = mode_r[`MODE_UP];
	end

	assign is_timer = (cfg.op == OP_TIMER);
	assign is_event = (cfg.op == OP_EVENT);

	// ---------------------------------------------------------------
	// count sources
	// ---------------------------------------------------------------
	count_source u_src (
		.clk      (SYS_CLK),
		.rst_b    (RST_B),
		.sub_tick (SUBCLOCK_TICK),
		.sel      (cfg.src),
		.tick     (src_tick)
	);

	// gate off below 2; 2 counts while pin low, 3 while pin high
	assign gate_ok = !cfg.gate[1] || (COUNT_INPUT_PIN == cfg.gate[0]);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			cin_prev_r <= COUNT_INPUT_PIN;
		end else begin
			cin_prev_r <= COUNT_INPUT_PIN;
		end
	end

	assign pin_edge = cfg.fall ? (cin_prev_r && !COUNT_INPUT_PIN)
	                           : (!cin_prev_r && COUNT_INPUT_PIN);

	always_comb begin
		case (cfg.evt)
			EVT_PIN:      evt_tick = pin_edge;
			EVT_SECOND_B: evt_tick = SECOND_B_GROUP_TIMER_OVF;
			EVT_FIRST_X:  evt_tick = FIRST_X_TIMER_OVF;
			EVT_THIRD_X:  evt_tick = THIRD_X_TIMER_OVF;
			default:      evt_tick = 1'b0;
		endcase
	end

	// pin high counts up, low counts down
	assign up = is_event && (cfg.dir_pin ? PULSE_OUTPUT_PIN_I : cfg.up);

	assign tick = start_r && ((is_timer && src_tick && gate_ok)
	                          || (is_event && evt_tick));

	// ---------------------------------------------------------------
	// counter and reload register
	// ---------------------------------------------------------------
	assign wrap_pt    = up ? (cnt_r == `CNT_TOP) : (cnt_r == `CNT_BOTTOM);
	assign wrap       = tick && wrap_pt;
	assign reload_evt = wrap && !(is_event && cfg.free_run);

	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_data && !start_r) begin
			cnt_nxt = wd16;
		end else if (reload_evt) begin
			cnt_nxt = reload_r;
		end else if (tick) begin
			cnt_nxt = up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			cnt_r <= `CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			reload_r <= `CNT_RST;
		end else if (wr_data) begin
			reload_r <= wd16;
		end
	end

	// ---------------------------------------------------------------
	// interrupt request and pulse pin
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= wrap;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			pout_r <= 1'b0;
		end else if (wrap && cfg.pulse) begin
			pout_r <= !pout_r;
		end
	end

	assign IRQ_REQ = irq_r;

	always_comb begin
		if (is_event && cfg.dir_pin) begin
			PULSE_OUTPUT_PIN_O  = 1'b0;
			PULSE_OUTPUT_PIN_OE = 1'b0;
		end else if ((is_timer || is_event) && cfg.pulse) begin
			PULSE_OUTPUT_PIN_O  = pout_r;
			PULSE_OUTPUT_PIN_OE = 1'b1;
		end else begin
			PULSE_OUTPUT_PIN_O  = PORT_DATA;
			PULSE_OUTPUT_PIN_OE = PORT_DIR;
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	assign ar_hs         = S_AXI_ARVALID && !rvalid_r;
	assign S_AXI_ARREADY = !rvalid_r;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rresp_r  <= `RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
			case (S_AXI_ARADDR)
				`OFS_CTRL:   rdata_r[`CTRL_START] <= start_r;
				`OFS_MODE:   rdata_r[`MODE_W-1:0] <= mode_r;
				`OFS_DATA:   rdata_r[15:0] <= cnt_r;
				`OFS_RELOAD: rdata_r[15:0] <= reload_r;
				`OFS_STATUS: rdata_r[2:0] <= {up, pout_r, tick};
				default:     rresp_r <= `RESP_SLVERR;
			endcase
		end else if (S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA  = rdata_r;
	assign S_AXI_RRESP  = rresp_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	property p_stop_hold;
		!start_r && !wr_data |=> $stable(cnt_r);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("counter moved while stopped");

	property p_tmr_reload;
		is_timer && tick && cnt_r == `CNT_BOTTOM
			|=> cnt_r == $past(reload_r);
	endproperty
	a_tmr_reload: assert property (p_tmr_reload)
		else $error("timer underflow did not reload");

	property p_irq;
		wrap |=> IRQ_REQ ##1 !IRQ_REQ || $past(wrap);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request not one pulse per wrap");

	property p_rd_count;
		ar_hs && S_AXI_ARADDR == `OFS_DATA
			|=> S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(cnt_r);
	endproperty
	a_rd_count: assert property (p_rd_count)
		else $error("data read did not return count");

	property p_wr_stop;
		wr_data && !start_r |=> cnt_r == reload_r && cnt_r == $past(wd16);
	endproperty
	a_wr_stop: assert property (p_wr_stop)
		else $error("stopped write did not load counter");

	property p_wr_run;
		wr_data && start_r && !tick
			|=> $stable(cnt_r) && reload_r == $past(wd16);
	endproperty
	a_wr_run: assert property (p_wr_run)
		else $error("running write disturbed counter");

	property p_gate;
		start_r && is_timer && cfg.gate[1]
			&& COUNT_INPUT_PIN != cfg.gate[0] |=> $stable(cnt_r);
	endproperty
	a_gate: assert property (p_gate)
		else $error("counter moved while gated off");

	property p_toggle;
		wrap && cfg.pulse |=> pout_r != $past(pout_r);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("pulse output did not toggle");

	property p_free;
		is_event && cfg.free_run && tick && up && cnt_r == `CNT_TOP
			|=> cnt_r == `CNT_BOTTOM;
	endproperty
	a_free: assert property (p_free)
		else $error("free run did not wrap to zero");

	property p_ev_reload;
		is_event && !cfg.free_run && wrap |=> cnt_r == $past(reload_r);
	endproperty
	a_ev_reload: assert property (p_ev_reload)
		else $error("event wrap did not reload");

	property p_dir;
		is_event && tick && !wrap_pt
			|=> cnt_r == ($past(up) ? $past(cnt_r) + 16'h0001
			                        : $past(cnt_r) - 16'h0001);
	endproperty
	a_dir: assert property (p_dir)
		else $error("event count went the wrong way");

endmodule // reload_timer

// ===== pulse_source.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// pins and overflow lines that face the timer
// ------------------------------------------------------------
module pulse_source #(
	parameter int SUB_P = 4
) (
	input  wire logic       clk,
	output logic            pin,
	output logic            dir,
	output logic            sub_tick,
	output logic [2:0]      ovf
);
	int sc = 0;
	initial begin
		pin = 1'b0;
		dir = 1'b1;
		sub_tick = 1'b0;
		ovf = 3'h0;
	end
	// free sub-clock, one tick every SUB_P cycles
	always @(posedge clk) begin
		sc <= (sc == SUB_P - 1) ? 0 : sc + 1;
		sub_tick <= (sc == SUB_P - 1);
	end
	// each toggle is one edge, three cycles apart
	task automatic toggles(input int n);
		repeat (n) begin
			@(posedge clk);
			pin <= ~pin;
			repeat (2) @(posedge clk);
		end
	endtask
	// one-cycle overflow pulses on line s
	task automatic pulses(input int s, input int n);
		repeat (n) begin
			@(posedge clk);
			ovf[s] <= 1'b1;
			@(posedge clk);
			ovf[s] <= 1'b0;
		end
	endtask
	task automatic level(input logic v);
		@(posedge clk);
		pin <= v;
	endtask
	// direction only changes between counted bursts
	task automatic direction(input logic v);
		@(posedge clk);
		dir <= v;
	endtask
endmodule // pulse_source

// ===== reload_timer_bench.sv
`timescale 1ns/1ns
module reload_timer_bench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        pdata = 1'b0;
	logic        pdir = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, n, d, e;
	logic        pin_o, pin_oe, pin_w, cpin, pdirw, sub, irq, t, p0, st;
	logic [2:0]  ovf;
	int          n_tests = 0;
	int          n_mismatch = 0;
	int          n_irq = 0;
	int          i, k, c, q;
	int          mul[4];
	logic [31:0] md[8] = '{32'h0000_0001, 32'h0000_1001, 32'h0000_0041,
		32'h0000_0021, 32'h0000_0021, 32'h0000_0401, 32'h0000_0801,
		32'h0000_0C01};
	logic [31:0] wm[3] = '{32'h0000_1005, 32'h0000_1085, 32'h0000_0045};
	logic [31:0] wn[3] = '{32'h0000_FFFD, 32'h0000_FFFD, 32'h0000_0002};
	logic [31:0] we[3] = '{32'h0000_FFFD, 32'h0000_0000, 32'h0000_0002};

	always #5 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;
	assign pin_w = pin_oe ? pin_o : pdirw;

	reload_timer dut_u (.SYS_CLK(clk), .RST_B(rst_b),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .COUNT_INPUT_PIN(cpin),
		.PULSE_OUTPUT_PIN_I(pin_w), .PULSE_OUTPUT_PIN_O(pin_o),
		.PULSE_OUTPUT_PIN_OE(pin_oe), .PORT_DATA(pdata), .PORT_DIR(pdir),
		.SUBCLOCK_TICK(sub), .SECOND_B_GROUP_TIMER_OVF(ovf[0]),
		.FIRST_X_TIMER_OVF(ovf[1]), .THIRD_X_TIMER_OVF(ovf[2]),
		.IRQ_REQ(irq));
	pulse_source #(.SUB_P(4)) p_u (.clk(clk), .pin(cpin), .dir(pdirw),
		.sub_tick(sub), .ovf(ovf));

	// ------------------------------------------------------------
	// report and compare
	// ------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic tmo();
		n_mismatch++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		conclude();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// edges of the chosen kind among k toggles from level s
	function automatic logic [31:0] edg(input logic s, input int k,
		input logic f);
		return (s ^ f) ? k / 2 : (k + 1) / 2;
	endfunction

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		logic ga, gw, gb;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int j = 0; j < 64; j++) begin
			@(negedge clk);
			ga = awvalid & awready;
			gw = wvalid & wready;
			gb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ga) awvalid <= 1'b0;
			if (gw) wvalid <= 1'b0;
			if (gb) begin
				bready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic ga, gr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int j = 0; j < 64; j++) begin
			@(negedge clk);
			ga = arvalid & arready;
			gr = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clk);
			if (ga) arvalid <= 1'b0;
			if (gr) begin
				rready <= 1'b0;
				return;
			end
		end
		tmo();
	endtask
	// cycles between two interrupt pulses, and whether the pulse flipped
	task automatic gap(output int cn, output logic tg);
		logic a;
		k = 0;
		do begin @(negedge clk); k++; end while (irq !== 1'b1 && k < 9000);
		a = pin_o;
		cn = 0;
		do begin @(negedge clk); cn++; end while (irq !== 1'b1 && cn < 9000);
		if (cn >= 9000) tmo();
		tg = a ^ pin_o;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		mul = '{1, 8, 32, 128};
		c = $urandom(32'h0000_07f3);
		pdata <= 1'($urandom);
		pdir <= 1'($urandom);
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 4; i++) begin
			rd(8'(i * 4), d, r);
			chk(d, 0);
		end
		chk(pin_o, pdata);
		chk(pin_oe, pdir);
		rd(8'h14, d, r);
		chk(d, 0);
		chk(r, 2);
		wr(8'h14, 32'h0000_0005, r);
		chk(r, 2);
		wr(8'h0C, 32'h0000_1234, r);
		rd(8'h0C, d, r);
		chk(d, 0);
		wr(8'h04, 32'hFFFF_FFFF, r);
		rd(8'h04, d, r);
		chk(d, 32'h0000_1FFF);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			n = $urandom_range(1, 5);
			wr(8'h00, 0, r);
			wr(8'h04, (i << 8) | 4, r);
			wr(8'h08, n, r);
			rd(8'h0C, d, r);
			chk(d, n);
			wr(8'h00, 1, r);
			gap(c, t);
			chk(c, mul[i] * (n + 1));
			chk({t, pin_oe}, 2'b11);
		end
		n = $urandom_range(6, 12);
		wr(8'h08, n, r);
		rd(8'h0C, d, r);
		chk(d, n);
		gap(c, t);
		gap(c, t);
		chk(c, mul[3] * (n + 1));
		wr(8'h00, 0, r);
		rd(8'h08, d, r);
		repeat (20) @(posedge clk);
		rd(8'h08, e, r);
		chk(e, d);
		$display("test timer done");
		for (i = 2; i < 4; i++) begin
			wr(8'h00, 0, r);
			wr(8'h04, i << 3, r);
			wr(8'h08, 32'h0000_0100, r);
			p_u.level(i == 2);
			wr(8'h00, 1, r);
			rd(8'h08, d, r);
			chk(d, 32'h0000_0100);
			p_u.level(i == 3);
			repeat (5) @(posedge clk);
			rd(8'h08, e, r);
			chk(e < d, 1);
		end
		$display("test gate done");
		for (i = 0; i < 8; i++) begin
			n = $urandom_range(40, 2000);
			k = $urandom_range(1, 9);
			wr(8'h00, 0, r);
			wr(8'h04, md[i], r);
			wr(8'h08, n, r);
			p_u.direction(i != 4);
			st = cpin;
			wr(8'h00, 1, r);
			if (i == 3) chk(pin_oe, 0);
			if (i < 5) p_u.toggles(k);
			else p_u.pulses(i - 5, k);
			e = (i < 5) ? edg(st, k, i == 2) : k;
			wr(8'h00, 0, r);
			rd(8'h08, d, r);
			chk(d, (i == 1 || i == 3) ? n + e : n - e);
		end
		$display("test event done");
		for (i = 0; i < 3; i++) begin
			wr(8'h00, 0, r);
			wr(8'h04, wm[i], r);
			wr(8'h08, wn[i], r);
			p_u.level(i == 2);
			wr(8'h00, 1, r);
			p0 = pin_o;
			q = n_irq;
			p_u.toggles(6);
			repeat (3) @(posedge clk);
			chk(n_irq - q, 1);
			chk({pin_o ^ p0, pin_oe}, 2'b11);
			wr(8'h00, 0, r);
			rd(8'h10, d, r);
			chk(d, {29'h0, 1'(i < 2), ~p0, 1'b0});
			rd(8'h08, d, r);
			chk(d, we[i]);
		end
		$display("test wrap done");
		conclude();
	end
endmodule // reload_timer_bench
